//--- verilog/lhr_header_rx.sv
// Header receiver top: break and sync detection, flags, interrupt and AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
module lhr_header_rx (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// AXI4-Lite write channels.
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read channels.
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// LIN line and serial receiver.
	input  wire logic        lin_rx,
	output logic             serial_receive_input,
	input  wire logic        id_received,
	input  wire logic        response_done,
	output logic             response_phase,
	// Interrupt.
	output logic             irq
);
	lhr_pkg::lhr_state_t state;
	lhr_pkg::lhr_state_t next_state;
	lhr_pkg::lhr_ctrl_t  link_control_reg;
	lhr_pkg::lhr_ctrl_t  next_ctrl;
	logic [1:0]          link_status_reg;
	logic [1:0]          next_status;
	logic [1:0]          irq_mask;
	logic [1:0]          next_mask;
	logic [7:0]          interval_timer_prescaler;
	logic [7:0]          next_pre;
	logic [7:0]          interval_timer_counter;
	logic [7:0]          next_cnt;
	logic [15:0]         meas_count;
	logic [15:0]         next_meas;
	logic                rx_prev;
	logic                next_route_out;
	logic                next_resp_phase;

	logic                aw_held;
	logic [7:0]          aw_addr;
	logic                w_held;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                next_aw_held;
	logic [7:0]          next_aw_addr;
	logic                next_w_held;
	logic [31:0]         next_w_data;
	logic [3:0]          next_w_strb;
	logic                next_bvalid;
	logic [1:0]          next_bresp;
	logic                next_rvalid;
	logic [31:0]         next_rdata;
	logic [1:0]          next_rresp;

	logic                wr_do;
	logic                wr_lane0;
	logic                start_req;
	logic [1:0]          status_clr;
	logic [1:0]          status_set;
	logic                tmr_reload;
	logic                tmr_run;
	logic                tmr_tick;
	logic                tmr_expire;
	logic                brk_hit;
	logic                meas_done;
	logic [15:0]         meas_val;
	logic                sync_hit;
	logic                rx_fall;

	function automatic logic reg_known(input logic [7:0] a);
		reg_known = (a == lhr_pkg::OFF_CTRL) || (a == lhr_pkg::OFF_STAT) ||
			(a == lhr_pkg::OFF_MASK) || (a == lhr_pkg::OFF_PRE) ||
			(a == lhr_pkg::OFF_CNT) || (a == lhr_pkg::OFF_MEAS);
	endfunction

	assign rx_fall = rx_prev && !lin_rx;
	assign brk_hit = (state == lhr_pkg::ST_BREAK) && tmr_expire;
	assign sync_hit = (state == lhr_pkg::ST_SYNC) && meas_done;

	// A break is a low run that outlasts the timer; any high level restarts the count.
	assign tmr_reload = (state == lhr_pkg::ST_IDLE) || (state == lhr_pkg::ST_BREAK && lin_rx);
	assign tmr_run    = (state == lhr_pkg::ST_BREAK) || (state == lhr_pkg::ST_SYNC);

	lhr_interval_timer u_timer (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.reload   (tmr_reload),
		.run      (tmr_run),
		.prescale (interval_timer_prescaler),
		.count    (interval_timer_counter),
		.tick     (tmr_tick),
		.expire   (tmr_expire)
	);

	lhr_sync_meas u_meas (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.en      (state == lhr_pkg::ST_SYNC),
		.fall    (rx_fall),
		.tick    (tmr_tick),
		.done    (meas_done),
		.value   (meas_val)
	);

	// Header sequence.
	always_comb begin
		next_state = state;
		unique case (state)
			lhr_pkg::ST_IDLE:  next_state = state;
			lhr_pkg::ST_BREAK: if (brk_hit) next_state = lhr_pkg::ST_SYNC;
			lhr_pkg::ST_SYNC:  if (meas_done) next_state = lhr_pkg::ST_ID;
			lhr_pkg::ST_ID:    if (id_received) next_state = lhr_pkg::ST_RESP;
			lhr_pkg::ST_RESP:  if (response_done) next_state = lhr_pkg::ST_IDLE;
			default:           next_state = lhr_pkg::ST_IDLE;
		endcase
		if (start_req) begin
			next_state = lhr_pkg::ST_BREAK;
		end
		// The sync waveform reaches the receiver only on request; the break phase is held high, other phases pass.
		if (state == lhr_pkg::ST_SYNC) begin
			next_route_out = link_control_reg.route ? lin_rx : 1'b1;
		end else if (state == lhr_pkg::ST_BREAK) begin
			next_route_out = 1'b1;
		end else begin
			next_route_out = lin_rx;
		end
		next_resp_phase = (next_state == lhr_pkg::ST_RESP);
	end

	// Register writes and flags.
	assign wr_do    = aw_held && w_held && !s_axi_bvalid;
	assign wr_lane0 = wr_do && w_strb[0];
	assign start_req = wr_lane0 && aw_addr == lhr_pkg::OFF_CTRL && w_data[lhr_pkg::CTRL_START];
	assign status_set = {sync_hit, brk_hit};
	assign status_clr = (wr_lane0 && aw_addr == lhr_pkg::OFF_STAT) ? w_data[1:0] : 2'h0;

	always_comb begin
		next_ctrl   = link_control_reg;
		next_mask   = irq_mask;
		next_pre    = interval_timer_prescaler;
		next_cnt    = interval_timer_counter;
		// Flags hold until written with one; a new event in the clearing cycle wins.
		next_status = (link_status_reg & ~status_clr) | status_set;
		next_meas   = sync_hit ? meas_val : meas_count;
		if (wr_lane0) begin
			unique case (aw_addr)
				lhr_pkg::OFF_CTRL: next_ctrl = {w_data[lhr_pkg::CTRL_ROUTE],
					w_data[lhr_pkg::CTRL_SYNIE], w_data[lhr_pkg::CTRL_BRKIE]};
				lhr_pkg::OFF_MASK: next_mask = w_data[1:0];
				lhr_pkg::OFF_PRE:  next_pre  = w_data[7:0];
				lhr_pkg::OFF_CNT:  next_cnt  = w_data[7:0];
				default:           next_mask = irq_mask;
			endcase
		end
	end

	// Each flag reaches the line only when both its enable and its mask bit are set.
	assign irq = |(link_status_reg & irq_mask &
		{link_control_reg.sync_ie, link_control_reg.brk_ie});

	// AXI4-Lite slave: address and data are taken in either order, one write at a time.
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_comb begin
		next_aw_held = aw_held;
		next_aw_addr = aw_addr;
		next_w_held  = w_held;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_do) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = reg_known(aw_addr) ? lhr_pkg::RESP_OKAY : lhr_pkg::RESP_SLV;
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = reg_known(s_axi_araddr) ? lhr_pkg::RESP_OKAY : lhr_pkg::RESP_SLV;
			unique case (s_axi_araddr)
				lhr_pkg::OFF_CTRL: next_rdata = {28'h0000000, link_control_reg.route,
					link_control_reg.sync_ie, link_control_reg.brk_ie, 1'b0};
				lhr_pkg::OFF_STAT: next_rdata = {25'h0, state, link_status_reg};
				lhr_pkg::OFF_MASK: next_rdata = {30'h0, irq_mask};
				lhr_pkg::OFF_PRE:  next_rdata = {24'h000000, interval_timer_prescaler};
				lhr_pkg::OFF_CNT:  next_rdata = {24'h000000, interval_timer_counter};
				lhr_pkg::OFF_MEAS: next_rdata = {16'h0000, meas_count};
				default:           next_rdata = 32'h00000000;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state                    <= lhr_pkg::ST_IDLE;
			link_control_reg         <= '0;
			link_status_reg          <= 2'h0;
			irq_mask                 <= lhr_pkg::MASK_RST;
			interval_timer_prescaler <= lhr_pkg::PRE_RST;
			interval_timer_counter   <= lhr_pkg::CNT_RST;
			meas_count               <= 16'h0000;
			rx_prev                  <= 1'b1;
			serial_receive_input     <= 1'b1;
			response_phase           <= 1'b0;
			aw_held                  <= 1'b0;
			aw_addr                  <= 8'h00;
			w_held                   <= 1'b0;
			w_data                   <= 32'h00000000;
			w_strb                   <= 4'h0;
			s_axi_bvalid             <= 1'b0;
			s_axi_bresp              <= 2'h0;
			s_axi_rvalid             <= 1'b0;
			s_axi_rdata              <= 32'h00000000;
			s_axi_rresp              <= 2'h0;
		end else begin
			state                    <= next_state;
			link_control_reg         <= next_ctrl;
			link_status_reg          <= next_status;
			irq_mask                 <= next_mask;
			interval_timer_prescaler <= next_pre;
			interval_timer_counter   <= next_cnt;
			meas_count               <= next_meas;
			rx_prev                  <= lin_rx;
			serial_receive_input     <= next_route_out;
			response_phase           <= next_resp_phase;
			aw_held                  <= next_aw_held;
			aw_addr                  <= next_aw_addr;
			w_held                   <= next_w_held;
			w_data                   <= next_w_data;
			w_strb                   <= next_w_strb;
			s_axi_bvalid             <= next_bvalid;
			s_axi_bresp              <= next_bresp;
			s_axi_rvalid             <= next_rvalid;
			s_axi_rdata              <= next_rdata;
			s_axi_rresp              <= next_rresp;
		end
	end

	// Checks.
	sequence s_break_seen;
		brk_hit;
	endsequence
	sequence s_sync_seen;
		sync_hit;
	endsequence

	property p_start_arms;
		@(posedge ref_clk) disable iff (!rst_n) start_req |=> state == lhr_pkg::ST_BREAK;
	endproperty
	a_start_arms: assert property (p_start_arms) else $error("start did not arm break");

	property p_brk_flag;
		@(posedge ref_clk) disable iff (!rst_n) s_break_seen |=> link_status_reg[0];
	endproperty
	a_brk_flag: assert property (p_brk_flag) else $error("break flag not set");

	property p_brk_irq;
		@(posedge ref_clk) disable iff (!rst_n)
			s_break_seen ##0 (link_control_reg.brk_ie && irq_mask[0] && !wr_do) |=> irq;
	endproperty
	a_brk_irq: assert property (p_brk_irq) else $error("break irq missing");

	property p_no_irq_disabled;
		@(posedge ref_clk) disable iff (!rst_n)
			!link_control_reg.brk_ie && !link_control_reg.sync_ie |-> !irq;
	endproperty
	a_no_irq_disabled: assert property (p_no_irq_disabled) else $error("irq while off");

	property p_to_sync;
		@(posedge ref_clk) disable iff (!rst_n)
			s_break_seen ##0 !start_req |=> state == lhr_pkg::ST_SYNC;
	endproperty
	a_to_sync: assert property (p_to_sync) else $error("no sync phase after break");

	property p_meas_kept;
		@(posedge ref_clk) disable iff (!rst_n) s_sync_seen |=> meas_count == $past(meas_val);
	endproperty
	a_meas_kept: assert property (p_meas_kept) else $error("measurement lost");

	property p_route_block;
		@(posedge ref_clk) disable iff (!rst_n)
			state == lhr_pkg::ST_SYNC && !link_control_reg.route |=> serial_receive_input;
	endproperty
	a_route_block: assert property (p_route_block) else $error("sync leaked to rx");

	property p_sync_flag_irq;
		@(posedge ref_clk) disable iff (!rst_n)
			s_sync_seen ##0 (link_control_reg.sync_ie && irq_mask[1] && !wr_do) |=>
			link_status_reg[1] && irq;
	endproperty
	a_sync_flag_irq: assert property (p_sync_flag_irq) else $error("sync flag/irq");

	property p_id_to_resp;
		@(posedge ref_clk) disable iff (!rst_n)
			state == lhr_pkg::ST_ID && id_received && !start_req |=> response_phase;
	endproperty
	a_id_to_resp: assert property (p_id_to_resp) else $error("no response phase");

	property p_flag_sticky;
		@(posedge ref_clk) disable iff (!rst_n)
			link_status_reg[0] && !status_clr[0] |=> link_status_reg[0];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("break flag dropped");
endmodule
`default_nettype wire

//--- shared/lhr_pkg.sv
// Package with register map, field layout, reset values and states of the header receiver.
package lhr_pkg;
	localparam logic [7:0] OFF_CTRL  = 8'h00;
	localparam logic [7:0] OFF_STAT  = 8'h04;
	localparam logic [7:0] OFF_MASK  = 8'h08;
	localparam logic [7:0] OFF_PRE   = 8'h0c;
	localparam logic [7:0] OFF_CNT   = 8'h10;
	localparam logic [7:0] OFF_MEAS  = 8'h14;
	localparam int         CTRL_START = 0;
	localparam int         CTRL_BRKIE = 1;
	localparam int         CTRL_SYNIE = 2;
	localparam int         CTRL_ROUTE = 3;
	localparam int         STAT_BRK   = 0;
	localparam int         STAT_SYN   = 1;
	localparam logic [1:0] MASK_RST   = 2'h3;
	localparam logic [7:0] PRE_RST    = 8'hff;
	localparam logic [7:0] CNT_RST    = 8'hff;
	localparam logic [2:0] SYNC_EDGES = 3'h4;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLV   = 2'h2;

	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_BREAK = 5'h02,
		ST_SYNC  = 5'h04,
		ST_ID    = 5'h08,
		ST_RESP  = 5'h10
	} lhr_state_t;

	typedef struct packed {
		logic route;
		logic sync_ie;
		logic brk_ie;
	} lhr_ctrl_t;
endpackage

//--- verilog/lhr_interval_timer.sv
// Interval timer: prescaler and down counter that flag a programmed low period.
`timescale 1ns/1ps
`default_nettype none
module lhr_interval_timer (
	// Clock and reset.
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	// Control.
	input  wire logic       reload,
	input  wire logic       run,
	input  wire logic [7:0] prescale,
	input  wire logic [7:0] count,
	// Results.
	output logic            tick,
	output logic            expire
);
	logic [7:0] pcnt;
	logic [7:0] cnt;
	logic       done;
	logic [7:0] next_pcnt;
	logic [7:0] next_cnt;
	logic       next_done;

	// The period is (prescale + 1) * (count + 1) cycles.
	always_comb begin
		next_pcnt = pcnt;
		next_cnt  = cnt;
		next_done = done;
		tick      = 1'b0;
		expire    = 1'b0;
		if (reload) begin
			next_pcnt = prescale;
			next_cnt  = count;
			next_done = 1'b0;
		end else if (run) begin
			if (pcnt == 8'h00) begin
				tick      = 1'b1;
				next_pcnt = prescale;
				if (cnt == 8'h00) begin
					expire    = !done;
					next_done = 1'b1;
				end else begin
					next_cnt = cnt - 8'h01;
				end
			end else begin
				next_pcnt = pcnt - 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pcnt <= 8'h00;
			cnt  <= 8'h00;
			done <= 1'b1;
		end else begin
			pcnt <= next_pcnt;
			cnt  <= next_cnt;
			done <= next_done;
		end
	end
endmodule
`default_nettype wire

//--- verilog/lhr_sync_meas.sv
// Sync field measurement: counts timer ticks from the start bit to the fifth falling edge.
`timescale 1ns/1ps
`default_nettype none
module lhr_sync_meas (
	// Clock and reset.
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// Line and time base.
	input  wire logic        en,
	input  wire logic        fall,
	input  wire logic        tick,
	// Result.
	output logic             done,
	output logic [15:0]      value
);
	logic [2:0]  edges;
	logic [15:0] cnt;
	logic [2:0]  next_edges;
	logic [15:0] next_cnt;
	logic        next_done;
	logic [15:0] next_value;

	// 55h has falling edges at the start bit and bits 1, 3, 5, 7, so the fifth one closes bit 6.
	always_comb begin
		next_edges = edges;
		next_cnt   = cnt;
		next_done  = 1'b0;
		next_value = value;
		if (!en) begin
			next_edges = 3'h0;
			next_cnt   = 16'h0000;
		end else begin
			if (tick && edges != 3'h0) begin
				next_cnt = cnt + 16'h0001;
			end
			if (fall) begin
				if (edges == lhr_pkg::SYNC_EDGES) begin
					next_done  = 1'b1;
					next_value = next_cnt;
					next_edges = 3'h0;
				end else begin
					next_edges = edges + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			edges <= 3'h0;
			cnt   <= 16'h0000;
			done  <= 1'b0;
			value <= 16'h0000;
		end else begin
			edges <= next_edges;
			cnt   <= next_cnt;
			done  <= next_done;
			value <= next_value;
		end
	end
endmodule
`default_nettype wire

//--- sim/lhr_lin_master.sv
// Model of the LIN master node: drives break, delimiter and the sync byte onto the line.
`timescale 1ns/1ps
`default_nettype none
module lhr_lin_master (
	// Clock.
	input  wire logic        ref_clk,
	// Command from the bench.
	input  wire logic        go,
	input  wire logic [15:0] brk_cycles,
	input  wire logic [15:0] bit_cycles,
	// Line and progress.
	output logic             lin_rx,
	output logic             busy,
	output logic             in_sync
);
	// Start bit, 55h least significant bit first, then the stop bit.
	localparam logic [9:0] SYNC_FRAME = {1'b1, 8'h55, 1'b0};
	initial begin
		lin_rx = 1'b1;
		busy = 1'b0;
		in_sync = 1'b0;
	end
	// The line has a pull-up, so it is high whenever the master lets go of it.
	// A zero bit time sends a bare low pulse, used to probe the break threshold.
	always @(posedge ref_clk) begin
		if (go && !busy) begin
			busy <= 1'b1;
			lin_rx <= 1'b0;
			repeat (brk_cycles) @(posedge ref_clk);
			lin_rx <= 1'b1;
			if (bit_cycles != 16'h0000) begin
				repeat (bit_cycles) @(posedge ref_clk);
				in_sync <= 1'b1;
				// Bit 7 is low once the measurement is over and may reach the receiver then,
				// so the flag covers only the measured span, start bit to bit 6.
				for (int i = 0; i < 10; i++) begin
					lin_rx <= SYNC_FRAME[i];
					if (i == 8)
						in_sync <= 1'b0;
					repeat (bit_cycles) @(posedge ref_clk);
				end
			end
			busy <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- sim/lhr_header_rx_bench.sv
// Self-checking bench for the header receiver: registers, break, sync, flags, irq, phases.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin failures++; $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module lhr_header_rx_bench;
	logic        ref_clk;
	logic        rst_n;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd, rnd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic        lin_rx, serial_receive_input, id_received, response_done;
	logic        response_phase, irq, lin_go, m_busy, m_in_sync;
	logic [15:0] brk_len, bit_len, bl, m;
	logic [7:0]  pre, cnt;
	logic [2:0]  cfg;
	int          failures, checked, cycles, lows, thr, n;

	lhr_header_rx u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.lin_rx(lin_rx), .serial_receive_input(serial_receive_input),
		.id_received(id_received), .response_done(response_done),
		.response_phase(response_phase), .irq(irq));
	lhr_lin_master u_master (.ref_clk(ref_clk), .go(lin_go), .brk_cycles(brk_len),
		.bit_cycles(bit_len), .lin_rx(lin_rx), .busy(m_busy), .in_sync(m_in_sync));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] exp_status(input logic [1:0] fl, input lhr_pkg::lhr_state_t st);
		return {25'h0, st, fl};
	endfunction
	// Eight bit times from the first to the fifth falling edge, in prescaled ticks.
	function automatic logic [15:0] exp_meas(input logic [15:0] b, input logic [7:0] p);
		return (16'h0008 * b) / ({8'h00, p} + 16'h0001);
	endfunction

	task automatic conclude();
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// The run should take about a thousand cycles; the ceiling only catches a hang.
	always @(posedge ref_clk) begin
		cycles++;
		if (m_in_sync && !serial_receive_input)
			lows++;
		if (cycles == 30000) begin
			failures++;
			conclude();
		end
	end

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge ref_clk);
			if (!aw_ok && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic axi_rd(input logic [7:0] a);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge ref_clk);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
		axi_rd(a);
		`CHK(rd, e)
		`CHK(resp, lhr_pkg::RESP_OKAY)
	endtask

	task automatic send(input logic [15:0] b, input logic [15:0] t, input logic hold);
		lin_go <= 1'b1;
		brk_len <= b;
		bit_len <= t;
		@(posedge ref_clk);
		lin_go <= 1'b0;
		if (hold)
			do @(posedge ref_clk); while (m_busy);
	endtask

	task automatic pulse(input logic is_id);
		if (is_id)
			id_received <= 1'b1;
		else
			response_done <= 1'b1;
		@(posedge ref_clk);
		id_received <= 1'b0;
		response_done <= 1'b0;
		repeat (3) @(posedge ref_clk);
	endtask

	initial begin
		rst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, lin_go} = 6'h00;
		{id_received, response_done} = 2'h0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		brk_len = 16'h0;
		bit_len = 16'h0;
		{failures, checked, cycles, lows} = {32'd0, 32'd0, 32'd0, 32'd0};
		rnd = 32'h07a4804a;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk_rd(lhr_pkg::OFF_CTRL, 32'h0);
		chk_rd(lhr_pkg::OFF_STAT, exp_status(2'h0, lhr_pkg::ST_IDLE));
		chk_rd(lhr_pkg::OFF_MASK, {30'h0, lhr_pkg::MASK_RST});
		chk_rd(lhr_pkg::OFF_PRE, {24'h0, lhr_pkg::PRE_RST});
		chk_rd(lhr_pkg::OFF_CNT, {24'h0, lhr_pkg::CNT_RST});
		chk_rd(lhr_pkg::OFF_MEAS, 32'h0);
		axi_rd(8'h18);
		`CHK({rd, resp}, {32'h0, lhr_pkg::RESP_SLV})
		axi_wr(8'h1c, 32'hffffffff);
		`CHK(resp, lhr_pkg::RESP_SLV)
		for (int it = 0; it < 4; it++) begin
			rnd = lfsr(rnd);
			pre = (it == 0) ? 8'h00 : {6'h00, rnd[1:0]};
			cnt = {5'h01, rnd[4:2]};
			thr = (pre + 1) * (cnt + 1);
			bl = ({8'h00, pre} + 16'h1) * (16'h4 + {14'h0, rnd[6:5]});
			cfg = {it[0] ^ it[1], it[1], it[0]};
			axi_wr(lhr_pkg::OFF_PRE, {24'h0, pre});
			axi_wr(lhr_pkg::OFF_CNT, {24'h0, cnt});
			chk_rd(lhr_pkg::OFF_PRE, {24'h0, pre});
			axi_wr(lhr_pkg::OFF_CTRL, {28'h0, cfg, 1'b1});
			chk_rd(lhr_pkg::OFF_CTRL, {28'h0, cfg, 1'b0});
			chk_rd(lhr_pkg::OFF_STAT, exp_status(2'h0, lhr_pkg::ST_BREAK));
			send(thr[15:0] - 16'h1, 16'h0, 1'b1);
			chk_rd(lhr_pkg::OFF_STAT, exp_status(2'h0, lhr_pkg::ST_BREAK));
			lows = 0;
			send(thr[15:0] + 16'h2, bl, 1'b0);
			n = 0;
			do begin
				axi_rd(lhr_pkg::OFF_STAT);
				n++;
			end while (rd[0] !== 1'b1 && n < 300);
			`CHK(rd, exp_status(2'h1, lhr_pkg::ST_SYNC))
			`CHK(irq, cfg[0])
			while (m_busy) @(posedge ref_clk);
			repeat (4) @(posedge ref_clk);
			chk_rd(lhr_pkg::OFF_STAT, exp_status(2'h3, lhr_pkg::ST_ID));
			`CHK(irq, cfg[0] | cfg[1])
			`CHK(lows != 0, cfg[2])
			axi_rd(lhr_pkg::OFF_MEAS);
			m = exp_meas(bl, pre);
			`CHK((rd[15:0] + 16'h1 >= m) && (rd[15:0] <= m + 16'h1), 1'b1)
			axi_wr(lhr_pkg::OFF_MASK, 32'h1);
			`CHK(irq, cfg[0])
			axi_wr(lhr_pkg::OFF_MASK, 32'h3);
			axi_wr(lhr_pkg::OFF_STAT, 32'h0);
			chk_rd(lhr_pkg::OFF_STAT, exp_status(2'h3, lhr_pkg::ST_ID));
			axi_wr(lhr_pkg::OFF_STAT, 32'h1);
			chk_rd(lhr_pkg::OFF_STAT, exp_status(2'h2, lhr_pkg::ST_ID));
			`CHK(irq, cfg[1])
			axi_wr(lhr_pkg::OFF_STAT, 32'h2);
			`CHK(irq, 1'b0)
			pulse(1'b0);
			`CHK(response_phase, 1'b0)
			pulse(1'b1);
			`CHK(response_phase, 1'b1)
			chk_rd(lhr_pkg::OFF_STAT, exp_status(2'h0, lhr_pkg::ST_RESP));
			pulse(1'b0);
			`CHK(response_phase, 1'b0)
			chk_rd(lhr_pkg::OFF_STAT, exp_status(2'h0, lhr_pkg::ST_IDLE));
		end
		conclude();
	end
endmodule
`default_nettype wire
